// ---- inc/bcd_pkg.sv ----
// =============================================================
// shared constants for clip and destination register bank
// =============================================================
package bcd_pkg;
    // register byte addresses in the graphics register space
    localparam logic [19:0] OFF_CLIP_TOP = 20'h40008;
    localparam logic [19:0] OFF_CLIP_BOTTOM = 20'h4000C;
    localparam logic [19:0] OFF_CLIP_LR = 20'h40010;
    localparam logic [19:0] OFF_BG_COLOR = 20'h40014;
    localparam logic [19:0] OFF_FG_COLOR = 20'h40018;
    localparam logic [19:0] OFF_PAT_BASE = 20'h4001C;
    localparam logic [19:0] OFF_DEST_X = 20'h40020;
    localparam logic [19:0] OFF_DEST_START = 20'h40024;
    localparam logic [19:0] OFF_DEST_BOTTOM = 20'h40028;

    // field widths and positions
    localparam int ADDR_W = 26;
    localparam int COORD_W = 12;
    localparam int COLOR_W = 24;
    localparam int PITCH_W = 14;
    localparam int X_HI_LSB = 16;
    localparam int PAT_LSB = 6;

    // reset value of every register
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // colour depth codes
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_16 = 2'h1;
    localparam logic [1:0] DEPTH_24 = 2'h2;

    // pixels per pattern row
    localparam logic [8:0] PAT_ROW_PIX = 9'h008;

    // drawing instruction kinds presented with a load
    typedef enum logic [1:0] {
        BCD_INSTR_SETUP,
        BCD_INSTR_PIXEL,
        BCD_INSTR_SPAN,
        BCD_INSTR_GLYPH
    } bcd_instr_t;

    // engine walk states
    typedef enum logic [0:0] {
        BCD_IDLE,
        BCD_RUN
    } bcd_state_t;

    // bytes per pixel for a colour depth (reserved code counts as one)
    function automatic logic [1:0] bcd_bpp(input logic [1:0] depth);
        case (depth)
            DEPTH_16: bcd_bpp = 2'h2;
            DEPTH_24: bcd_bpp = 2'h3;
            default: bcd_bpp = 2'h1;
        endcase
    endfunction

    // keep only the colour bytes used at a depth
    function automatic logic [23:0] bcd_color_mask(input logic [23:0] c, input logic [1:0] depth);
        case (depth)
            DEPTH_24: bcd_color_mask = c;
            DEPTH_16: bcd_color_mask = {8'h00, c[15:0]};
            default: bcd_color_mask = {16'h0000, c[7:0]};
        endcase
    endfunction
endpackage

// ---- hw/bcd_pixel_unit.sv ----
`timescale 1ns/1ps
// =============================================================
// pixel address and clip test
// =============================================================
module bcd_pixel_unit (
    input wire logic [25:0] line_addr,
    input wire logic [11:0] x,
    input wire logic [1:0] depth,
    input wire logic [25:0] clip_top,
    input wire logic [25:0] clip_bottom,
    input wire logic [11:0] clip_left,
    input wire logic [11:0] clip_right,
    output logic [25:0] byte_addr,
    output logic pass
);
    // scaled coordinate, wide enough for x * 3
    logic [13:0] x_bytes;

    // address and clip decision
    always_comb
    begin
        x_bytes = 14'(x * bcd_pkg::bcd_bpp(depth));
        byte_addr = line_addr + {12'h000, x_bytes};
        pass = (line_addr >= clip_top)
            && (line_addr <= clip_bottom)
            && (x <= clip_right)
            && (x >= clip_left);
    end
endmodule

// ---- hw/bcd_clip_dest_regs.sv ----
`timescale 1ns/1ps
// Contract
// - write only lines at or below top clip
// - write only lines at or above bottom clip
// - right clip is inclusive
// - left clip is inclusive
// - byte address is line plus x times bpp
// - background colour for span and glyph expansion
// - background colour is single pixel solid colour
// - foreground colour for span and glyph expansion
// - colour bytes used follow colour depth
// - pattern rows are eight pixels of bytes
// - pattern base keeps bits 25..6, low zero
// - pattern base serves spans, depth matches system
// - setup loads clips, drawing applies them
// - single pixel loads only left x
// - left x advances while engine runs
// - destination address is working address
// - destination address written last, starts engine
// - each line start compared with clip lines
// - glyph walks from start line to bottom
// - depth code 00/01/10 is 8/16/24
module bcd_clip_dest_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic ld_en,
    input wire logic [19:0] ld_addr,
    input wire logic [31:0] ld_data,
    input wire logic [1:0] ld_instr,
    input wire logic rd_en,
    input wire logic [19:0] rd_addr,
    input wire logic [1:0] depth,
    input wire logic [13:0] dest_pitch,
    input wire logic mono_bit,
    input wire logic wr_ready,
    output logic [31:0] rd_data,
    output logic busy,
    output logic wr_valid,
    output logic [25:0] wr_addr,
    output logic [23:0] wr_color,
    output logic [25:0] pat_addr,
    output logic [8:0] pat_row_bytes
);
    // =============================================================
    // register bank
    logic [25:0] clip_top_address; // top clip line
    logic [25:0] clip_bottom_address; // bottom clip line
    logic [11:0] clip_left; // left clip x
    logic [11:0] clip_right; // right clip x
    logic [23:0] expand_background_color; // expansion background
    logic [23:0] expand_foreground_color; // expansion foreground
    logic [19:0] color_pattern_base; // pattern address bits 25..6
    logic [11:0] dest_x_left; // working left x
    logic [11:0] dest_x_right; // right x
    logic [25:0] dest_start_address; // working line address
    logic [25:0] dest_bottom_address; // last glyph line
    logic [25:0] next_clip_top_address, next_clip_bottom_address; // next bank values
    logic [25:0] next_dest_start_address, next_dest_bottom_address;
    logic [11:0] next_clip_left, next_clip_right, next_dest_x_left, next_dest_x_right;
    logic [23:0] next_expand_background_color, next_expand_foreground_color;
    logic [19:0] next_color_pattern_base;

    // =============================================================
    // engine state
    bcd_pkg::bcd_state_t state, next_state; // walk state
    bcd_pkg::bcd_instr_t run_instr, next_run_instr; // instruction being drawn
    logic [11:0] x_start, next_x_start; // left x of each line
    logic next_busy, next_wr_valid; // next output flags
    logic [25:0] next_wr_addr, next_pat_addr; // next output addresses
    logic [23:0] next_wr_color;
    logic [8:0] next_pat_row_bytes;
    logic [31:0] next_rd_data;

    // helper signals
    logic start; // destination address load
    logic stall; // write held by memory
    logic [25:0] pix_addr; // current pixel byte address
    logic pix_pass; // current pixel inside clip
    logic [11:0] x_end; // last x of the line
    logic [25:0] pitch_ext; // sign extended pitch
    logic [23:0] fg_used, bg_used; // depth masked colours

    // address and clip of the current pixel
    bcd_pixel_unit u_pix (
        .line_addr(dest_start_address),
        .x(dest_x_left),
        .depth(depth),
        .clip_top(clip_top_address),
        .clip_bottom(clip_bottom_address),
        .clip_left(clip_left),
        .clip_right(clip_right),
        .byte_addr(pix_addr),
        .pass(pix_pass)
    );

    // =============================================================
    // register loads from the instruction parser
    always_comb
    begin
        next_clip_top_address = clip_top_address;
        next_clip_bottom_address = clip_bottom_address;
        next_clip_left = clip_left;
        next_clip_right = clip_right;
        next_expand_background_color = expand_background_color;
        next_expand_foreground_color = expand_foreground_color;
        next_color_pattern_base = color_pattern_base;
        next_dest_x_right = dest_x_right;
        next_dest_bottom_address = dest_bottom_address;
        start = 1'b0;
        if (ld_en)
        begin
            // address bits 31..26 are dropped, kept zero by software
            case (ld_addr)
                bcd_pkg::OFF_CLIP_TOP: next_clip_top_address = ld_data[25:0];
                bcd_pkg::OFF_CLIP_BOTTOM: next_clip_bottom_address = ld_data[25:0];
                bcd_pkg::OFF_CLIP_LR:
                begin
                    next_clip_left = ld_data[11:0];
                    next_clip_right = ld_data[27:16];
                end
                bcd_pkg::OFF_BG_COLOR: next_expand_background_color = ld_data[23:0];
                bcd_pkg::OFF_FG_COLOR: next_expand_foreground_color = ld_data[23:0];
                bcd_pkg::OFF_PAT_BASE: next_color_pattern_base = ld_data[25:6];
                bcd_pkg::OFF_DEST_X:
                begin
                    // single pixel leaves right x alone
                    if (ld_instr != bcd_pkg::BCD_INSTR_PIXEL)
                    begin
                        next_dest_x_right = ld_data[27:16];
                    end
                end
                bcd_pkg::OFF_DEST_START: start = 1'b1;
                bcd_pkg::OFF_DEST_BOTTOM: next_dest_bottom_address = ld_data[25:0];
                default: start = 1'b0;
            endcase
        end
    end

    // =============================================================
    // engine walk: lines and pixels
    always_comb
    begin
        stall = wr_valid && !wr_ready;
        pitch_ext = {{12{dest_pitch[13]}}, dest_pitch};
        fg_used = bcd_pkg::bcd_color_mask(expand_foreground_color, depth);
        bg_used = bcd_pkg::bcd_color_mask(expand_background_color, depth);
        x_end = (run_instr == bcd_pkg::BCD_INSTR_PIXEL) ? dest_x_left : dest_x_right;
        next_state = state;
        next_run_instr = run_instr;
        next_x_start = x_start;
        next_dest_x_left = dest_x_left;
        next_dest_start_address = dest_start_address;
        next_busy = busy;
        next_wr_valid = stall ? wr_valid : 1'b0;
        next_wr_addr = wr_addr;
        next_wr_color = wr_color;
        case (state)
            bcd_pkg::BCD_IDLE:
            begin
                // left x load only while idle, the engine owns it when busy
                if (ld_en && ld_addr == bcd_pkg::OFF_DEST_X)
                begin
                    next_dest_x_left = ld_data[11:0];
                end
                if (start)
                begin
                    next_dest_start_address = ld_data[25:0];
                    next_run_instr = bcd_pkg::bcd_instr_t'(ld_instr);
                    next_x_start = dest_x_left;
                    next_state = bcd_pkg::BCD_RUN;
                    next_busy = 1'b1;
                end
            end
            bcd_pkg::BCD_RUN:
            begin
                if (!stall)
                begin
                    // clipped pixels are skipped without a write
                    next_wr_valid = pix_pass;
                    next_wr_addr = pix_addr;
                    if (run_instr == bcd_pkg::BCD_INSTR_PIXEL)
                    begin
                        next_wr_color = bg_used;
                    end
                    else
                    begin
                        next_wr_color = mono_bit ? fg_used : bg_used;
                    end
                    if (dest_x_left >= x_end)
                    begin
                        // end of a line: glyphs step down to the bottom line
                        if (run_instr == bcd_pkg::BCD_INSTR_GLYPH
                            && dest_start_address != dest_bottom_address)
                        begin
                            next_dest_start_address = dest_start_address + pitch_ext;
                            next_dest_x_left = x_start;
                        end
                        else
                        begin
                            next_state = bcd_pkg::BCD_IDLE;
                            next_busy = 1'b0;
                        end
                    end
                    else
                    begin
                        next_dest_x_left = dest_x_left + 12'h001;
                    end
                end
            end
            default:
            begin
                next_state = bcd_pkg::BCD_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // =============================================================
    // pattern fetch and register read
    always_comb
    begin
        // pattern base serves span drawing at the system depth
        next_pat_addr = {color_pattern_base, 6'h00};
        next_pat_row_bytes = 9'(bcd_pkg::PAT_ROW_PIX * bcd_pkg::bcd_bpp(depth));
        next_rd_data = rd_data;
        if (rd_en)
        begin
            case (rd_addr)
                bcd_pkg::OFF_CLIP_TOP: next_rd_data = {6'h00, clip_top_address};
                bcd_pkg::OFF_CLIP_BOTTOM: next_rd_data = {6'h00, clip_bottom_address};
                bcd_pkg::OFF_CLIP_LR: next_rd_data = {4'h0, clip_right, 4'h0, clip_left};
                bcd_pkg::OFF_BG_COLOR: next_rd_data = {8'h00, expand_background_color};
                bcd_pkg::OFF_FG_COLOR: next_rd_data = {8'h00, expand_foreground_color};
                bcd_pkg::OFF_PAT_BASE: next_rd_data = {6'h00, color_pattern_base, 6'h00};
                bcd_pkg::OFF_DEST_X: next_rd_data = {4'h0, dest_x_right, 4'h0, dest_x_left};
                bcd_pkg::OFF_DEST_START: next_rd_data = {6'h00, dest_start_address};
                bcd_pkg::OFF_DEST_BOTTOM: next_rd_data = {6'h00, dest_bottom_address};
                default: next_rd_data = bcd_pkg::REG_RESET;
            endcase
        end
    end

    // =============================================================
    // state registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clip_top_address <= bcd_pkg::REG_RESET[25:0];
            clip_bottom_address <= bcd_pkg::REG_RESET[25:0];
            clip_left <= bcd_pkg::REG_RESET[11:0];
            clip_right <= bcd_pkg::REG_RESET[11:0];
            expand_background_color <= bcd_pkg::REG_RESET[23:0];
            expand_foreground_color <= bcd_pkg::REG_RESET[23:0];
            color_pattern_base <= bcd_pkg::REG_RESET[19:0];
            dest_x_left <= bcd_pkg::REG_RESET[11:0];
            dest_x_right <= bcd_pkg::REG_RESET[11:0];
            dest_start_address <= bcd_pkg::REG_RESET[25:0];
            dest_bottom_address <= bcd_pkg::REG_RESET[25:0];
            state <= bcd_pkg::BCD_IDLE;
            run_instr <= bcd_pkg::BCD_INSTR_SETUP;
            x_start <= bcd_pkg::REG_RESET[11:0];
            busy <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= bcd_pkg::REG_RESET[25:0];
            wr_color <= bcd_pkg::REG_RESET[23:0];
            pat_addr <= bcd_pkg::REG_RESET[25:0];
            pat_row_bytes <= bcd_pkg::REG_RESET[8:0];
            rd_data <= bcd_pkg::REG_RESET;
        end
        else if (ce)
        begin
            clip_top_address <= next_clip_top_address;
            clip_bottom_address <= next_clip_bottom_address;
            clip_left <= next_clip_left;
            clip_right <= next_clip_right;
            expand_background_color <= next_expand_background_color;
            expand_foreground_color <= next_expand_foreground_color;
            color_pattern_base <= next_color_pattern_base;
            dest_x_left <= next_dest_x_left;
            dest_x_right <= next_dest_x_right;
            dest_start_address <= next_dest_start_address;
            dest_bottom_address <= next_dest_bottom_address;
            state <= next_state;
            run_instr <= next_run_instr;
            x_start <= next_x_start;
            busy <= next_busy;
            wr_valid <= next_wr_valid;
            wr_addr <= next_wr_addr;
            wr_color <= next_wr_color;
            pat_addr <= next_pat_addr;
            pat_row_bytes <= next_pat_row_bytes;
            rd_data <= next_rd_data;
        end
    end

    // =============================================================
    // checks
    a_top_clip: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && !stall && dest_start_address < clip_top_address
        |=> !wr_valid)
        else $error("write above top clip");
    a_bottom_clip: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && !stall && dest_start_address > clip_bottom_address
        |=> !wr_valid)
        else $error("write below bottom clip");
    a_right_clip: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && !stall && dest_x_left > clip_right |=> !wr_valid)
        else $error("write right of clip");
    a_left_clip: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && !stall && dest_x_left < clip_left |=> !wr_valid)
        else $error("write left of clip");
    a_addr_form: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && !stall && pix_pass
        |=> wr_valid && wr_addr == $past(dest_start_address)
            + 26'($past(dest_x_left) * bcd_pkg::bcd_bpp($past(depth))))
        else $error("pixel address wrong");
    a_pixel_bg: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && run_instr == bcd_pkg::BCD_INSTR_PIXEL && !stall
        |=> wr_color == $past(bg_used))
        else $error("single pixel colour not background");
    a_pat_low: assert property (@(posedge clk) disable iff (!rst_b)
        ce && rd_en && rd_addr == bcd_pkg::OFF_PAT_BASE |=> rd_data[5:0] == 6'h00)
        else $error("pattern low bits not zero");
    a_start_run: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_IDLE && start |=> busy && state == bcd_pkg::BCD_RUN)
        else $error("start did not start engine");
    a_pixel_one: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == bcd_pkg::BCD_RUN && run_instr == bcd_pkg::BCD_INSTR_PIXEL && !stall
        |=> !busy)
        else $error("single pixel ran past one pixel");
endmodule

// ---- tb/bcd_fb_model.sv ----
`timescale 1ns/1ps
// ========
// frame buffer write side
// ========
module bcd_fb_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic wr_valid,
    input wire logic [25:0] wr_addr,
    input wire logic [23:0] wr_color,
    output logic wr_ready
);
    logic [49:0] q[$]; // accepted writes, address over colour
    logic ph = 1'b0; // stall phase
    // takes a write on every edge, or every other edge when stalling
    always @(posedge clk)
    begin
        ph <= ~ph;
        if (wr_valid && wr_ready)
            q.push_back({wr_addr, wr_color});
    end
    assign wr_ready = ~stall | ph;
endmodule

// ---- tb/test_blit_clip_and_destination_regs.sv ----
`timescale 1ns/1ps
// ========
// bench for clip and destination registers
// ========
module test_blit_clip_and_destination_regs;
    logic clk = 1'b0, rst_b = 1'b0, ld_en = 1'b0, rd_en = 1'b0, mono_bit = 1'b0, stall = 1'b0;
    logic [19:0] ld_addr = 20'h00000, rd_addr = 20'h00000;
    logic [31:0] ld_data = 32'h0, rd_data;
    logic [1:0] ld_instr = 2'h0, depth = 2'h0;
    logic [13:0] pitch = 14'h0000; // line step for glyphs
    logic ce = 1'b1; // clock enable, dropped once to check the freeze
    logic busy, wr_valid, wr_ready;
    logic [25:0] wr_addr, pat_addr, top, bot;
    logic [23:0] wr_color, fg, bg;
    logic [8:0] row_bytes;
    logic [11:0] cl, cr; // clip columns as loaded
    int fails = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    bcd_clip_dest_regs dut (.clk(clk), .rst_b(rst_b), .ce(ce), .ld_en(ld_en),
        .ld_addr(ld_addr), .ld_data(ld_data), .ld_instr(ld_instr), .rd_en(rd_en),
        .rd_addr(rd_addr), .depth(depth), .dest_pitch(pitch), .mono_bit(mono_bit),
        .wr_ready(wr_ready), .rd_data(rd_data), .busy(busy), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_color(wr_color), .pat_addr(pat_addr),
        .pat_row_bytes(row_bytes));
    bcd_fb_model fm (.clk(clk), .stall(stall), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_color(wr_color), .wr_ready(wr_ready));
    // ========
    // shared tasks
    // ========
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // an idle edge, then one parser load
    task automatic load(input logic [19:0] a, input logic [31:0] d, input logic [1:0] k);
        @(posedge clk);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
        ld_instr <= k;
        @(posedge clk);
        ld_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(rd_data, e);
    endtask
    // a load while the clock enable is low leaves the bank untouched
    task automatic frozen(input logic [31:0] keep);
        @(posedge clk);
        ce <= 1'b0;
        load(20'h40018, 32'h0065_4321, 2'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(20'h40018, keep);
    endtask
    // clip rectangle through a setup load; high address bits kept zero
    task automatic setup(input logic [25:0] t, b, input logic [11:0] l, r);
        top = t;
        bot = b;
        cl = l;
        cr = r;
        load(20'h40008, {6'h00, t}, 2'h0);
        load(20'h4000C, {6'h00, b}, 2'h0);
        load(20'h40010, {4'h0, r, 4'h0, l}, 2'h0);
        rd_chk(20'h40010, {4'h0, r, 4'h0, l});
    endtask
    // run one drawing instruction and compare every write reaching memory
    task automatic draw(input logic [1:0] k, input logic [25:0] ln, input logic [11:0] x1, x2,
                        input logic [25:0] yb);
        logic [49:0] exp[$];
        logic [25:0] l;
        logic [23:0] c;
        int n;
        int bpp;
        // let inputs driven just before the call settle first
        @(posedge clk);
        l = ln;
        bpp = depth == 2'h3 ? 1 : depth + 1;
        c = mono_bit && k != 2'h1 ? fg : bg;
        c = depth == 2'h2 ? c : depth == 2'h1 ? {8'h00, c[15:0]} : {16'h0000, c[7:0]};
        for (n = 0; n < 16; n++)
        begin
            for (int x = x1; x <= (k == 2'h1 ? x1 : x2); x++)
                if (l >= top && l <= bot && x >= cl && x <= cr)
                    exp.push_back({l + 26'(x * bpp), c});
            if (k != 2'h3 || l == yb)
                break;
            l = l + {{12{pitch[13]}}, pitch};
        end
        fm.q.delete();
        load(20'h40020, {4'h0, x2, 4'h0, x1}, k);
        load(20'h40028, {6'h00, yb}, k);
        load(20'h40024, {6'h00, ln}, k);
        #1 check({31'h0, busy}, 32'h1);
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while ((busy !== 1'b0 || wr_valid !== 1'b0) && n < 300);
        if (n >= 300)
        begin
            fails++;
            conclude();
        end
        check(32'(fm.q.size()), 32'(exp.size()));
        for (int i = 0; i < exp.size() && i < fm.q.size(); i++)
        begin
            check({6'h00, fm.q[i][49:24]}, {6'h00, exp[i][49:24]});
            check({8'h00, fm.q[i][23:0]}, {8'h00, exp[i][23:0]});
        end
    endtask
    // ========
    // main sequence
    // ========
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // every register clear after reset, unmapped place reads zero
        for (int a = 8; a <= 'h2C; a += 4)
            rd_chk(20'h40000 + 20'(a), 32'h0);
        load(20'h4001C, 32'h02AB_CD00, 2'h0);
        rd_chk(20'h4001C, 32'h02AB_CD00);
        check({6'h00, pat_addr}, 32'h02AB_CD00);
        // low six bits of a base are dropped
        load(20'h4001C, 32'h02AB_CDFF, 2'h0);
        rd_chk(20'h4001C, 32'h02AB_CDC0);
        // pattern row size for each depth code, reserved as 8bpp
        for (int d = 0; d < 4; d++)
        begin
            @(posedge clk);
            depth <= 2'(d);
            @(posedge clk);
            #1 check({23'h0, row_bytes}, d == 3 ? 32'h8 : 32'(8 * (d + 1)));
        end
        fg = 24'h123456;
        bg = 24'hABCDEF;
        load(20'h40018, {8'h00, fg}, 2'h0);
        load(20'h40014, {8'h00, bg}, 2'h0);
        frozen({8'h00, fg});
        // span clipped left and right at 16bpp, memory stalling
        depth <= 2'h1;
        stall <= 1'b1;
        mono_bit <= 1'b1;
        setup(26'h0000100, 26'h0000300, 12'h002, 12'h004);
        draw(2'h2, 26'h0000200, 12'h001, 12'h005, 26'h0);
        // vertical clip edges with background expansion
        mono_bit <= 1'b0;
        draw(2'h2, 26'h00000FF, 12'h002, 12'h002, 26'h0);
        draw(2'h2, 26'h0000300, 12'h002, 12'h003, 26'h0);
        draw(2'h2, 26'h0000301, 12'h002, 12'h002, 26'h0);
        // single pixel load keeps right x, draws solid background at 24bpp
        load(20'h40020, 32'h0007_0001, 2'h2);
        load(20'h40020, 32'h0009_0003, 2'h1);
        rd_chk(20'h40020, 32'h0007_0003);
        depth <= 2'h2;
        // expansion bit set, single pixel must still use background
        mono_bit <= 1'b1;
        draw(2'h1, 26'h0000200, 12'h003, 12'h003, 26'h0);
        // glyph over three lines, first above the top clip, no stall
        depth <= 2'h0;
        stall <= 1'b0;
        mono_bit <= 1'b1;
        pitch <= 14'h0040;
        setup(26'h0000140, 26'h0000300, 12'h000, 12'h00A);
        draw(2'h3, 26'h0000100, 12'h004, 12'h005, 26'h0000180);
        conclude();
    end
endmodule
